// File: design/bsr_readout.sv
/*
  serial command decoder and readout shifter of the sensor interface.
  assumes the host drives sclk and din, an external converter returns
  results on adc_valid/adc_data, and only sclk and din are asynchronous.
*/
`timescale 1ns/1ps
module bsr_readout
  import bsr_pkg::*;
(
  input  wire logic        core_clk,     // core clock, 50 MHz
  input  wire logic        rst,          // sync reset, high
  input  wire logic        sclk_pin,     // serial clock from host
  input  wire logic        din_pin,      // serial data from host
  output logic             dout,         // serial data to host
  output logic             conv_start,   // one-cycle conversion request
  output logic             conv_temp,    // high: temperature requested
  input  wire logic        adc_valid,    // converter result offered
  input  wire logic [15:0] adc_data,     // converter result word
  output logic             adc_ready     // buffer can take a result
);

  // ***************************************************
  // pin synchronisation
  // ***************************************************
  logic [1:0] pins_s;                    // synchronised sclk, din
  logic       sclk_s;                    // synchronised serial clock
  logic       din_s;                     // synchronised data in

  // both pins pass two flops before use
  bsr_sync #(
    .WIDTH    (2)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({sclk_pin, din_pin}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  // ***************************************************
  // result buffer
  // ***************************************************
  logic        res_valid;                // buffered result present
  logic        res_ready;                // shifter takes result
  logic [15:0] res_data;                 // buffered result word
  logic        fifo_in_ready;            // buffer has room

  // converter output waits here until the shifter wants it
  bsr_fifo #(
    .WIDTH     (RESULT_BITS),
    .DEPTH     (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (adc_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (adc_data),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  // ***************************************************
  // core state
  // ***************************************************
  typedef struct packed {
    bsr_state_type st;                   // interface state
    logic          sclk_prev;            // last sclk sample
    logic [20:0]   hist;                 // recent data-in bits
    logic [3:0]    nbits;                // bits since idle, saturating
    logic [1:0]    tail;                 // clocks after acknowledge
    logic [4:0]    rd_cnt;               // readout clocks seen
    logic [15:0]   shreg;                // word being shifted out
    logic          dout;                 // data-out level
    logic          conv_start;           // request pulse
    logic          conv_temp;            // conversion kind
    logic          adc_ready;            // buffer room, registered
  } bsr_core_type;

  bsr_core_type s;                       // registered state
  bsr_core_type next_s;                  // next state

  // calibration words, most significant first
  logic [3:0][15:0] cal_words;           // word one at index 3
  assign cal_words = CAL_DEFAULT;

  // shifter takes a result only while converting
  assign res_ready = (s.st == BSR_CONV);

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb
  begin
    logic rise;                          // sclk rising edge
    logic framed;                        // valid frame in history
    rise      = sclk_s & ~s.sclk_prev;
    next_s    = s;
    framed    = 1'b0;
    next_s.conv_start = 1'b0;
    next_s.sclk_prev  = sclk_s;
    next_s.adc_ready  = fifo_in_ready;

    // every rising edge shifts one data-in bit into history
    if (rise)
    begin
      next_s.hist = {s.hist[19:0], din_s};
      if (s.nbits != FRAME_FULL)
      begin
        next_s.nbits = s.nbits + 4'h1;
      end
    end

    // frame check: start marker, setup, stop marker
    framed = (next_s.nbits == FRAME_FULL)
           && (next_s.hist[9:7] == START_MARK)
           && (next_s.hist[2:0] == STOP_MARK);

    if (rise && (next_s.hist == RESET_PATTERN))
    begin
      // reset pattern wins in every state
      next_s.st     = BSR_IDLE;
      next_s.hist   = '0;
      next_s.nbits  = '0;
      next_s.tail   = '0;
      next_s.rd_cnt = '0;
      next_s.dout   = 1'b0;
    end
    else
    begin
      case (s.st)
        // hunting for a command
        BSR_IDLE:
        begin
          if (rise && framed)
          begin
            // decode the four-bit setup field
            case (next_s.hist[6:3])
              CODE_PRESSURE, CODE_TEMP:
              begin
                // acknowledge the start on the last stop bit
                next_s.conv_temp = (next_s.hist[6:3] == CODE_TEMP);
                next_s.dout      = 1'b1;
                next_s.st        = BSR_ACK;
                next_s.tail      = '0;
              end
              CODE_CAL_ONE:
              begin
                next_s.shreg  = cal_words[3];
                next_s.dout   = 1'b0;
                next_s.st     = BSR_READ;
                next_s.rd_cnt = '0;
              end
              CODE_CAL_TWO:
              begin
                next_s.shreg  = cal_words[2];
                next_s.dout   = 1'b0;
                next_s.st     = BSR_READ;
                next_s.rd_cnt = '0;
              end
              CODE_CAL_THR:
              begin
                next_s.shreg  = cal_words[1];
                next_s.dout   = 1'b0;
                next_s.st     = BSR_READ;
                next_s.rd_cnt = '0;
              end
              CODE_CAL_FOUR:
              begin
                next_s.shreg  = cal_words[0];
                next_s.dout   = 1'b0;
                next_s.st     = BSR_READ;
                next_s.rd_cnt = '0;
              end
              default:
              begin
                // unknown setup: keep hunting
                next_s.st = BSR_IDLE;
              end
            endcase
          end
        end

        // two further clocks, then the conversion starts
        BSR_ACK:
        begin
          if (rise)
          begin
            if (s.tail == ACK_LAST)
            begin
              next_s.st         = BSR_CONV;
              next_s.conv_start = 1'b1;
            end
            else
            begin
              next_s.tail = s.tail + 2'h1;
            end
          end
        end

        // waiting: result from the buffer ends the conversion
        BSR_CONV:
        begin
          if (res_valid)
          begin
            next_s.shreg  = res_data;
            next_s.dout   = 1'b0;
            next_s.st     = BSR_READ;
            next_s.rd_cnt = '0;
          end
        end

        // shift out msb first; a stalled sclk simply waits
        BSR_READ:
        begin
          if (rise)
          begin
            if (s.rd_cnt == READ_LAST)
            begin
              // seventeenth clock closes the readout
              next_s.dout  = 1'b0;
              next_s.st    = BSR_IDLE;
              next_s.nbits = '0;
            end
            else
            begin
              next_s.dout   = s.shreg[15];
              next_s.shreg  = {s.shreg[14:0], 1'b0};
              next_s.rd_cnt = s.rd_cnt + 5'h1;
            end
          end
        end

        default:
        begin
          next_s.st = BSR_IDLE;
        end
      endcase
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ***************************************************
  // outputs, all from flops
  // ***************************************************
  assign dout       = s.dout;
  assign conv_start = s.conv_start;
  assign conv_temp  = s.conv_temp;
  assign adc_ready  = s.adc_ready;

endmodule // bsr_readout

// File: include/bsr_pkg.sv
/*
  constants, codes and types of the barometric sensor serial readout.
  assumes one core clock at 50 MHz and a host that owns the serial clock.
*/
package bsr_pkg;

  // ***************************************************
  // frame layout
  // ***************************************************
  localparam int          FRAME_BITS   = 10;      // start+setup+stop
  localparam int          RESET_BITS   = 21;      // reset pattern length
  localparam int          RESULT_BITS  = 16;      // result word width
  localparam logic [4:0]  READ_LAST    = 5'h10;   // 17th readout clock
  localparam logic [1:0]  ACK_LAST     = 2'h1;    // 2 clocks after ack
  localparam logic [3:0]  FRAME_FULL   = 4'ha;    // bits in a frame
  localparam logic [2:0]  START_MARK   = 3'h7;    // three high bits
  localparam logic [2:0]  STOP_MARK    = 3'h0;    // three low bits
  localparam int          FIFO_DEPTH   = 4;       // result buffer depth

  // ***************************************************
  // setup codes and reset pattern
  // ***************************************************
  localparam logic [3:0]  CODE_PRESSURE = 4'ha;   // pressure conversion
  localparam logic [3:0]  CODE_TEMP     = 4'h9;   // temperature conversion
  localparam logic [3:0]  CODE_CAL_ONE  = 4'h5;   // calibration word one
  localparam logic [3:0]  CODE_CAL_TWO  = 4'h6;   // calibration word two
  localparam logic [3:0]  CODE_CAL_THR  = 4'h3;   // calibration word three
  localparam logic [3:0]  CODE_CAL_FOUR = 4'hc;   // calibration word four
  localparam logic [20:0] RESET_PATTERN = 21'h155540; // alternating, 6 low

  // ***************************************************
  // calibration store, values arbitrary
  // ***************************************************
  localparam logic [63:0] CAL_DEFAULT = 64'h1234_5678_9abc_def0;

  // ***************************************************
  // interface states
  // ***************************************************
  typedef enum logic [1:0] {
    BSR_IDLE = 2'b00,   // hunting for a command frame
    BSR_ACK  = 2'b01,   // counting clocks after acknowledge
    BSR_CONV = 2'b10,   // waiting for the converter result
    BSR_READ = 2'b11    // shifting a word out
  } bsr_state_type;

endpackage

// File: design/bsr_sync.sv
/*
  two-flop synchroniser for a group of asynchronous pin levels.
  assumes the pins are quasi-static compared with the core clock.
*/
`timescale 1ns/1ps
module bsr_sync
  import bsr_pkg::*;
#(
  parameter int WIDTH = 2                    // number of levels
)(
  input  wire logic             core_clk,    // core clock
  input  wire logic             rst,         // sync reset, high
  input  wire logic [WIDTH-1:0] async_in,    // raw pin levels
  output logic      [WIDTH-1:0] sync_out     // resynchronised levels
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta;                  // first stage only
    logic [WIDTH-1:0] safe;                  // second stage
  } bsr_sync_type;

  bsr_sync_type s;                           // registered state
  bsr_sync_type next_s;                      // next state

  // stage shift
  always_comb
  begin
    next_s      = s;
    next_s.meta = async_in;
    next_s.safe = s.meta;
  end

  // register the copy
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sync_out = s.safe;

endmodule // bsr_sync

// File: design/bsr_fifo.sv
/*
  small result buffer between converter and serial shifter.
  assumes both sides sit on the core clock.
*/
`timescale 1ns/1ps
module bsr_fifo
  import bsr_pkg::*;
#(
  parameter int WIDTH = 16,                  // word width
  parameter int DEPTH = 4                    // words held
)(
  input  wire logic             core_clk,    // core clock
  input  wire logic             rst,         // sync reset, high
  input  wire logic             in_valid,    // word offered
  output logic                  in_ready,    // room available
  input  wire logic [WIDTH-1:0] in_data,     // word in
  output logic                  out_valid,   // word available
  input  wire logic             out_ready,   // word taken
  output logic      [WIDTH-1:0] out_data     // word out
);

  localparam int AW = $clog2(DEPTH);        // pointer width

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;        // storage
    logic [AW-1:0]               wr_ptr;     // write index
    logic [AW-1:0]               rd_ptr;     // read index
    logic [AW:0]                 count;      // words held
    logic                        in_ready;   // not full
    logic                        out_valid;  // not empty
  } bsr_fifo_type;

  bsr_fifo_type s;                           // registered state
  bsr_fifo_type next_s;                      // next state

  // push, pop and flag update
  always_comb
  begin
    logic push;
    logic pop;
    push   = in_valid & s.in_ready;
    pop    = out_ready & s.out_valid;
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr        = (s.wr_ptr == AW'(DEPTH - 1)) ? '0
                             : s.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0
                      : s.rd_ptr + 1'b1;
    end
    next_s.count     = s.count + (AW+1)'(push) - (AW+1)'(pop);
    next_s.in_ready  = (next_s.count != (AW+1)'(DEPTH));
    next_s.out_valid = (next_s.count != '0);
  end

  // register the copy
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s          <= '0;
      s.in_ready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign in_ready  = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data  = s.mem[s.rd_ptr];

endmodule // bsr_fifo

// File: sim/bsr_readout_properties.sv
/*
  concurrent checks on the ports of the serial readout.
  assumes one core clock domain with synchronous active-high reset.
*/
`timescale 1ns/1ps
module bsr_readout_properties
  import bsr_pkg::*;
(
  input wire logic        core_clk,   // core clock
  input wire logic        rst,        // sync reset, high
  input wire logic        sclk_pin,   // host serial clock
  input wire logic        din_pin,    // host serial data
  input wire logic        dout,       // device serial data
  input wire logic        conv_start, // conversion request
  input wire logic        conv_temp,  // request type
  input wire logic        adc_valid,  // converter word offered
  input wire logic [15:0] adc_data,   // converter word
  input wire logic        adc_ready   // buffer has room
);
  logic       sclk_q;      // pin level at previous edge
  logic [3:0] since_rise;  // edges since pin rise, saturating
  logic       conv_wait;   // request out, completion pending

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // track serial clock rises and outstanding conversions
  always_ff @(posedge core_clk)
  begin
    sclk_q <= sclk_pin;
    if (rst)
      since_rise <= 4'hf;
    else if (sclk_pin && !sclk_q)
      since_rise <= 4'h0;
    else if (since_rise != 4'hf)
      since_rise <= since_rise + 4'h1;
    if (rst)
      conv_wait <= 1'b0;
    else if (conv_start)
      conv_wait <= 1'b1;
    else if ($fell(dout))
      conv_wait <= 1'b0;
  end

  a_rst_quiet: assert property (
    $fell(rst) |-> !dout && !conv_start && !conv_temp)
    else $error("outputs not idle after reset");
  a_ready_release: assert property (
    $fell(rst) |-> ##[1:3] adc_ready)
    else $error("buffer not ready after reset");
  a_start_pulse: assert property (
    conv_start |=> !conv_start [*8])
    else $error("conversion request too long or too close");
  a_start_clocked: assert property (
    conv_start |-> since_rise <= 4'hc)
    else $error("conversion request without serial clock");
  a_dout_rise_cause: assert property (
    $rose(dout) |-> since_rise inside {[1:5]})
    else $error("data-out rose away from a clock rise");
  a_dout_fall_cause: assert property (
    $fell(dout) |-> since_rise inside {[1:5]} || conv_wait
      || conv_start || $past(conv_start))
    else $error("data-out fell without cause");
  a_temp_change: assert property (
    $changed(conv_temp) |-> $rose(dout))
    else $error("request type changed outside a request");
  a_ready_cause: assert property (
    $fell(adc_ready) |-> $past(adc_valid) || $past(adc_valid, 2))
    else $error("buffer refused without traffic");

  c_temp_req: cover property (conv_start && conv_temp);
  c_eoc:      cover property ($fell(dout) && conv_wait);
  c_full:     cover property (adc_valid && !adc_ready);
endmodule // bsr_readout_properties

// File: sim/bsr_host.sv
/*
  host model: owns the serial clock, sends frames, captures data-out.
  assumes a 160 ns serial clock that stands low between transfers.
*/
`timescale 1ns/1ps
module bsr_host
  import bsr_pkg::*;
(
  output logic      sclk_pin,  // serial clock, idle low
  output logic      din_pin,   // serial data to device
  input  wire logic dout       // serial data from device
);
  logic [16:0] sh;             // captured bits, newest at bit 0

  initial
  begin
    sclk_pin = 1'b0;
    din_pin  = 1'b0;
    sh       = 17'h0;
  end

  // capture data-out shortly after each falling edge
  always @(negedge sclk_pin)
  begin
    #16 sh = {sh[15:0], dout};
  end

  // one clock: data changes at the fall, then 80/80 ns pulse
  task automatic bit_out(input logic b);
    din_pin = b;
    #80 sclk_pin = 1'b1;
    #80 sclk_pin = 1'b0;
  endtask

  task automatic frame(input logic [3:0] code);
    logic [9:0] f;
    f = {START_MARK, code, STOP_MARK};
    for (int i = 9; i >= 0; i--) bit_out(f[i]);
  endtask

  task automatic clocks(input int n);
    for (int i = 0; i < n; i++) bit_out(1'b0);
  endtask

  task automatic send_reset;
    for (int i = 20; i >= 0; i--) bit_out(RESET_PATTERN[i]);
  endtask
endmodule // bsr_host

// File: sim/test_baro_sensor_serial_readout.sv
/*
  self-checking bench: host model on the link, converter model on the
  result side, queues hold the expected words.
  assumes the package, design and host model are compiled first.
*/
`timescale 1ns/1ps
module test_baro_sensor_serial_readout
  import bsr_pkg::*;
;
  logic        core_clk, rst, sclk_pin, din_pin, dout;
  logic        conv_start, conv_temp, adc_valid, adc_ready;
  logic [15:0] adc_data;    // converter word
  logic        last_temp;   // type seen at last request
  int          n_errors;    // mismatches
  int          checks_done; // comparisons
  int          n_start;     // requests seen
  logic [15:0] exp_q[$];    // accepted words, readout order
  logic [15:0] pend[$];     // words waiting to be offered
  logic [3:0]  cal_code[4];  // calibration read codes

  bsr_readout dut (
    .core_clk(core_clk), .rst(rst), .sclk_pin(sclk_pin),
    .din_pin(din_pin), .dout(dout), .conv_start(conv_start),
    .conv_temp(conv_temp), .adc_valid(adc_valid),
    .adc_data(adc_data), .adc_ready(adc_ready));
  bsr_host host (.sclk_pin(sclk_pin), .din_pin(din_pin), .dout(dout));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // converter model: offers pending words, records accepted ones
  // stands in for the converter, clocked by the core clock
  always @(posedge core_clk)
  begin
    if (conv_start)
    begin
      n_start   <= n_start + 1;
      last_temp <= conv_temp;
    end
    if (adc_valid && adc_ready)
    begin
      exp_q.push_back(adc_data);
      adc_valid <= 1'b0;
    end
    else if (!adc_valid && pend.size() > 0)
    begin
      adc_data  <= pend.pop_front();
      adc_valid <= 1'b1;
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t: %s bit %b not %b", $time, m, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                          input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t: %s %h not %h", $time, m, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // 17 clocks with a hold of the serial clock after the eighth
  task automatic read_word(input logic [15:0] exp, input int pause);
    host.clocks(8);
    #(pause);
    host.clocks(9);
    #20;
    chk_word(host.sh[16:1], exp, "word");
    chk_bit(host.sh[0], 1'b0, "tail");
  endtask

  task automatic cal_read(input int k);
    host.frame(cal_code[k]);
    #20;
    chk_bit(host.sh[0], 1'b0, "cal ack");
    read_word(CAL_DEFAULT[63-16*k -: 16], 0);
  endtask

  task automatic convert(input logic temp, input logic late);
    int n0;
    int t;
    n0 = n_start;
    host.frame(temp ? CODE_TEMP : CODE_PRESSURE);
    #20;
    chk_bit(host.sh[0], 1'b1, "ack");
    host.clocks(2);
    #200;
    chk_word(16'(n_start - n0), 16'h1, "requests");
    chk_bit(last_temp, temp, "type");
    if (late)
    begin
      chk_bit(dout, 1'b1, "busy");
      pend.push_back(16'($urandom));
    end
    t = 0;
    while (dout !== 1'b0 && t < 5000)
    begin
      #20;
      t++;
    end
    chk_bit(dout, 1'b0, "done");
    read_word(exp_q.pop_front(), $urandom_range(100, 5) * 20);
  endtask

  initial
  begin
    #1_000_000;
    n_errors++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    rst = 1'b1;
    adc_valid = 1'b0;
    adc_data = 16'h0;
    n_errors = 0;
    checks_done = 0;
    n_start = 0;
    last_temp = 1'b0;
    cal_code = '{CODE_CAL_ONE, CODE_CAL_TWO, CODE_CAL_THR, CODE_CAL_FOUR};
    void'($urandom(56388));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #87;
    host.send_reset();
    #20;
    chk_bit(dout, 1'b0, "idle");
    for (int k = 0; k < 4; k++) cal_read(k);
    $display("test calibration done");
    repeat (5) pend.push_back(16'($urandom));
    #800;
    chk_bit(adc_ready, 1'b0, "full");
    chk_word(16'(exp_q.size()), 16'(FIFO_DEPTH), "depth");
    for (int k = 0; k < 5; k++) convert(k[0], 1'b0);
    $display("test buffered conversions done");
    host.frame(4'h0);
    #20;
    chk_word(16'(n_start), 16'h5, "ignored frame");
    host.frame(cal_code[2]);
    host.clocks(5);
    host.send_reset();
    cal_read(2);
    host.frame(CODE_PRESSURE);
    host.clocks(2);
    host.send_reset();
    cal_read(3);
    $display("test resync done");
    convert(1'b1, 1'b1);
    $display("test late result done");
    stop_test();
  end
endmodule // test_baro_sensor_serial_readout

bind bsr_readout bsr_readout_properties chk (
  .core_clk(core_clk), .rst(rst), .sclk_pin(sclk_pin),
  .din_pin(din_pin), .dout(dout), .conv_start(conv_start),
  .conv_temp(conv_temp), .adc_valid(adc_valid),
  .adc_data(adc_data), .adc_ready(adc_ready));
